/* hdl/wdt_pkg.sv */
// shared constants, register map and types for the 16-bit watchdog timer
package wdt_pkg;

	// ****************************************
	// widths and register map
	// ****************************************
	localparam int WDT_DATA_W = 32;
	localparam int WDT_CNT_W = 16;
	localparam int WDT_PRE_W = 8;
	localparam logic [31:0] WDT_ADDR_RELOAD = 32'hFFFF0360;
	localparam logic [31:0] WDT_ADDR_COUNT = 32'hFFFF0364;
	localparam logic [31:0] WDT_ADDR_CTRL = 32'hFFFF0368;
	localparam logic [31:0] WDT_ADDR_REFRESH = 32'hFFFF036C;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [15:0] WDT_RELOAD_RST = 16'h0040;
	localparam logic [15:0] WDT_COUNT_RST = 16'h0040;
	localparam logic [15:0] WDT_CTRL_RST = 16'h0000;

	// ****************************************
	// control field positions
	// ****************************************
	localparam int WDT_BIT_UP = 8;
	localparam int WDT_BIT_EN = 7;
	localparam int WDT_BIT_PERIODIC = 6;
	localparam int WDT_BIT_WATCHDOG = 5;
	localparam int WDT_BIT_PRE_HI = 3;
	localparam int WDT_BIT_PRE_LO = 2;
	localparam int WDT_BIT_IRQEN = 1;
	localparam int WDT_BIT_PDSTOP = 0;
	// writable positions; reserved bits read as zero
	localparam logic [15:0] WDT_CTRL_MASK = 16'h01EF;

	// ****************************************
	// prescaler codes and terminal counts
	// ****************************************
	localparam logic [1:0] WDT_PRE_DIV1 = 2'h0;
	localparam logic [1:0] WDT_PRE_DIV16 = 2'h1;
	localparam logic [1:0] WDT_PRE_DIV256 = 2'h2;
	localparam logic [7:0] WDT_DIV16_TOP = 8'h0F;
	localparam logic [7:0] WDT_DIV256_TOP = 8'hFF;

	// ****************************************
	// timing
	// ****************************************
	localparam int WDT_LP_OSC_HZ = 32768;
	localparam int WDT_PCLK_HZ = 20000000;
	localparam int WDT_MAX_TIMEOUT_S = 512;
	localparam int WDT_MAX_DIV = 256;
	localparam longint WDT_FULL_SCALE = 65536;
	localparam longint WDT_MAX_TIMEOUT_CALC = WDT_FULL_SCALE * WDT_MAX_DIV / WDT_LP_OSC_HZ;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic count_up;
		logic enable;
		logic periodic;
		logic watchdog;
		logic [1:0] prescale;
		logic irq_enable;
		logic powerdown_stop;
	} wdt_ctrl_t;

	typedef struct packed {
		logic wrap;
		logic wd_zero;
	} wdt_evt_t;

	typedef enum logic [1:0] {
		WDT_MODE_NORMAL = 2'b01,
		WDT_MODE_WATCH = 2'b10
	} wdt_mode_t;

	function automatic wdt_ctrl_t wdt_unpack(input logic [15:0] v);
		wdt_ctrl_t c;
		c.count_up = v[WDT_BIT_UP];
		c.enable = v[WDT_BIT_EN];
		c.periodic = v[WDT_BIT_PERIODIC];
		c.watchdog = v[WDT_BIT_WATCHDOG];
		c.prescale = v[WDT_BIT_PRE_HI:WDT_BIT_PRE_LO];
		c.irq_enable = v[WDT_BIT_IRQEN];
		c.powerdown_stop = v[WDT_BIT_PDSTOP];
		return c;
	endfunction

endpackage

/* hdl/wdt_tick.sv */
// oscillator pin synchroniser and 1/16/256 prescaler
`timescale 1ns/1ps
module wdt_tick
	import wdt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic lp_osc,
	input wire logic run,
	input wire logic [1:0] prescale,
	output logic tick
);
	logic osc_meta;
	logic osc_sync;
	logic osc_prev;
	logic [WDT_PRE_W-1:0] pre_cnt;
	wire osc_edge = osc_sync & ~osc_prev;
	wire [WDT_PRE_W-1:0] pre_top = (prescale == WDT_PRE_DIV16) ? WDT_DIV16_TOP :
		(prescale == WDT_PRE_DIV256) ? WDT_DIV256_TOP : '0;
	// reserved prescaler code gives no ticks
	wire pre_ok = (prescale == WDT_PRE_DIV1) || (prescale == WDT_PRE_DIV16) ||
		(prescale == WDT_PRE_DIV256);
	// leftover count from a longer divider must not stall a shorter one
	wire pre_hit = (pre_cnt >= pre_top);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
			osc_prev <= 1'b0;
			pre_cnt <= '0;
			tick <= 1'b0;
		end
		else if (ce)
		begin
			osc_meta <= lp_osc;
			osc_sync <= osc_meta;
			osc_prev <= osc_sync;
			tick <= 1'b0;
			if (osc_edge && run && pre_ok)
			begin
				pre_cnt <= pre_hit ? '0 : pre_cnt + 1'b1;
				tick <= pre_hit;
			end
		end
	end
endmodule

/* hdl/wdt_count.sv */
// 16-bit up/down counter with reload, wrap and zero events
`timescale 1ns/1ps
module wdt_count
	import wdt_pkg::*;
#(
	parameter int CNT_W = WDT_CNT_W
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic tick,
	input wire logic load,
	input wire logic [CNT_W-1:0] reload,
	input wire wdt_ctrl_t ctrl,
	output logic [CNT_W-1:0] count,
	output wdt_evt_t evt
);
	if (CNT_W != WDT_CNT_W)
	begin
		$error("wdt_count: counter width must be 16");
	end

	wire down = ctrl.watchdog | ~ctrl.count_up;
	wire run = ctrl.watchdog | ctrl.enable;
	wire at_end = down ? (count == '0) : (count == '1);
	wire reload_mode = ctrl.periodic | ctrl.watchdog;
	wire [CNT_W-1:0] wrap_val = down ? '1 : '0;
	wire [CNT_W-1:0] step_val = down ? count - 1'b1 : count + 1'b1;
	wire [CNT_W-1:0] end_val = reload_mode ? reload : wrap_val;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= WDT_COUNT_RST;
			evt <= '0;
		end
		else if (ce)
		begin
			evt <= '0;
			if (load)
				count <= reload;
			else if (tick && run)
			begin
				count <= at_end ? end_val : step_val;
				evt.wrap <= at_end & ~ctrl.watchdog;
				evt.wd_zero <= ctrl.watchdog & (count == 16'h0001);
			end
		end
	end
endmodule

/* hdl/wdt_top.sv */
// watchdog timer top: APB register file, lock, event outputs
`timescale 1ns/1ps

// Overview of operation
// - Setting watchdog bit enters watchdog mode, counting down from reload to zero.
// - At zero in watchdog mode: interrupt if IRQ enable set, else reset.
// - Refresh write in watchdog mode reloads counter and starts a new period.
// - After watchdog mode entry, reload and control writes are ignored until power-on.
// - Only power-on reset clears the watchdog; other resets leave it running.
// - Counter freezes while debug holds the core, resumes on release.
// - Counts in peripheral power-down unless powerdown_stop bit set.
// - Reload and count are 16-bit unsigned; count is read-only, shows counter.
// - Refresh is 8-bit write-only; in normal mode clears timer interrupt.
// - Control bit 8 sets up counting when set, down when clear.
// - Control bit 7 enables the counter.
// - Control bit 6 selects periodic reload, else free-running.
// - Control bits 3:2 divide oscillator by 1, 16, 256; code 11 reserved.
// - Divide by 256 with full-scale reload gives 512 s maximum timeout.
// - Overflow or underflow reloads counter from reload register in periodic or watchdog mode; free-running wraps.
// - Normal mode is a 16-bit timer on the prescaled low-power oscillator.
module wdt_top
	import wdt_pkg::*;
#(
	parameter int CNT_W = WDT_CNT_W
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lp_osc,
	input wire logic debug_halt,
	input wire logic periph_powerdown,
	output logic wdt_irq,
	output logic wdt_reset_req,
	output logic wdt_locked
);
	// ****************************************
	// elaboration checks
	// ****************************************
	if (CNT_W != WDT_CNT_W)
	begin
		$error("wdt_top: counter width must be 16");
	end
	if (WDT_MAX_TIMEOUT_CALC != WDT_MAX_TIMEOUT_S)
	begin
		$error("wdt_top: maximum timeout inconsistent");
	end

	// ****************************************
	// declarations
	// ****************************************
	logic [CNT_W-1:0] reload_value;
	logic [15:0] timer_control;
	wdt_mode_t mode;
	wdt_mode_t next_mode;
	logic irq_flag;
	logic dbg_meta;
	logic dbg_sync;
	logic tick;
	logic [CNT_W-1:0] count_value;
	wdt_evt_t evt;
	wdt_ctrl_t ctrl;

	// ****************************************
	// APB decode
	// ****************************************
	wire sel_reload = (paddr == WDT_ADDR_RELOAD);
	wire sel_count = (paddr == WDT_ADDR_COUNT);
	wire sel_ctrl = (paddr == WDT_ADDR_CTRL);
	wire sel_refresh = (paddr == WDT_ADDR_REFRESH);
	wire addr_hit = sel_reload | sel_count | sel_ctrl | sel_refresh;
	wire setup_rd = psel & ~penable & ~pwrite;
	wire access_wr = psel & penable & pwrite & addr_hit;
	wire locked = (mode == WDT_MODE_WATCH);
	// locked writes complete without error but do not store
	wire wr_reload = access_wr & sel_reload & ~locked;
	wire wr_ctrl = access_wr & sel_ctrl & ~locked;
	wire wr_refresh = access_wr & sel_refresh;
	wire [15:0] ctrl_wdata = pwdata[15:0] & WDT_CTRL_MASK;
	wire wdt_ctrl_t new_ctrl = wdt_unpack(ctrl_wdata);
	wire enter_watch = wr_ctrl & new_ctrl.watchdog;
	wire start_timer = wr_ctrl & new_ctrl.enable & ~ctrl.enable;

	assign ctrl = wdt_unpack(timer_control);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;

	// ****************************************
	// read data, captured in setup phase
	// ****************************************
	wire [31:0] rd_mux = sel_reload ? {16'h0000, reload_value} :
		sel_count ? {16'h0000, count_value} :
		sel_ctrl ? {16'h0000, timer_control} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (ce && setup_rd)
			prdata <= rd_mux;
	end

	// ****************************************
	// configuration registers, power-on reset only
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reload_value <= WDT_RELOAD_RST;
			timer_control <= WDT_CTRL_RST;
		end
		else if (ce)
		begin
			if (wr_reload)
				reload_value <= pwdata[CNT_W-1:0];
			if (wr_ctrl)
				timer_control <= ctrl_wdata;
		end
	end

	// ****************************************
	// mode: once watchdog, stays until power-on
	// ****************************************
	always_comb
	begin
		next_mode = mode;
		case (mode)
			WDT_MODE_NORMAL:
				if (enter_watch)
					next_mode = WDT_MODE_WATCH;
			WDT_MODE_WATCH:
				next_mode = WDT_MODE_WATCH;
			default:
				next_mode = WDT_MODE_NORMAL;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode <= WDT_MODE_NORMAL;
		else if (ce)
			mode <= next_mode;
	end

	assign wdt_locked = locked;

	// ****************************************
	// debug halt synchroniser and run gate
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dbg_meta <= 1'b0;
			dbg_sync <= 1'b0;
		end
		else if (ce)
		begin
			dbg_meta <= debug_halt;
			dbg_sync <= dbg_meta;
		end
	end

	wire pd_halt = ctrl.powerdown_stop & periph_powerdown;
	wire run = ~dbg_sync & ~pd_halt;

	// ****************************************
	// prescaler and counter
	// ****************************************
	wdt_tick u_tick
	(
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.lp_osc(lp_osc),
		.run(run),
		.prescale(ctrl.prescale),
		.tick(tick)
	);

	// refresh in watchdog mode reloads; entry and enable also load
	wire counter_load = (wr_refresh & locked) | enter_watch | start_timer;

	wdt_count #(.CNT_W(CNT_W)) u_count
	(
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.tick(tick),
		.load(counter_load),
		.reload(reload_value),
		.ctrl(ctrl),
		.count(count_value),
		.evt(evt)
	);

	// ****************************************
	// interrupt flag and reset request
	// ****************************************
	wire irq_set = evt.wrap | (evt.wd_zero & ctrl.irq_enable);
	wire reset_set = evt.wd_zero & ~ctrl.irq_enable;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_flag <= 1'b0;
			wdt_reset_req <= 1'b0;
		end
		else if (ce)
		begin
			// set wins over a refresh in the same cycle
			if (irq_set)
				irq_flag <= 1'b1;
			else if (wr_refresh)
				irq_flag <= 1'b0;
			wdt_reset_req <= reset_set;
		end
	end

	assign wdt_irq = irq_flag;
endmodule

/* test/wdt_checker.sv */
// assertions on the watchdog timer top ports
`timescale 1ns/1ps
module wdt_checker
	import wdt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic debug_halt,
	input wire logic wdt_irq,
	input wire logic wdt_reset_req,
	input wire logic wdt_locked
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire wr_acc = psel && penable && pwrite;
	wire rd_set = psel && !penable && !pwrite;
	wire rf_wr = wr_acc && paddr == WDT_ADDR_REFRESH;
	wire lock_wr = wr_acc && paddr == WDT_ADDR_CTRL && pwdata[WDT_BIT_WATCHDOG];
	// ****************************************
	// properties
	// ****************************************
	req_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req)
		else $error("reset request longer than one cycle");
	req_locked_a: assert property (wdt_reset_req |-> wdt_locked)
		else $error("reset request outside watchdog mode");
	lock_holds_a: assert property (wdt_locked |=> wdt_locked)
		else $error("lock dropped without power-on reset");
	lock_cause_a: assert property ($rose(wdt_locked) |-> $past(lock_wr))
		else $error("lock without control write");
	irq_sticky_a: assert property (wdt_irq && !rf_wr |=> wdt_irq)
		else $error("interrupt dropped without refresh");
	irq_clear_a: assert property ($fell(wdt_irq) |-> $past(rf_wr))
		else $error("interrupt cleared by other cause");
	rd_upper_a: assert property (rd_set |=> prdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	rf_zero_a: assert property (rd_set && paddr == WDT_ADDR_REFRESH |=> prdata == 32'h0)
		else $error("refresh location readable");
	halt_quiet_a: assert property (debug_halt [*8] |-> !wdt_reset_req && !$rose(wdt_irq))
		else $error("event while debug holds core");
	cover property (wdt_reset_req);
	cover property ($rose(wdt_irq) && wdt_locked);
	cover property (rf_wr && wdt_locked);
endmodule
bind wdt_top wdt_checker wdt_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.debug_halt(debug_halt), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req),
	.wdt_locked(wdt_locked));

/* test/wdt_core_model.sv */
// processor core model taking watchdog reset requests
`timescale 1ns/1ps
module wdt_core_model
(
	input wire logic pclk,
	input wire logic wdt_reset_req,
	output int n_rst
);
	int n_req = 0;
	// core reset stays inside the core; watchdog is not reset
	always @(posedge pclk)
		if (wdt_reset_req === 1'b1)
			n_req <= n_req + 1;
	assign n_rst = n_req;
endmodule

/* test/wdt_top_tb.sv */
// self-checking bench for the watchdog timer over APB
`timescale 1ns/1ps
module wdt_top_tb;
	import wdt_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic lp_osc = 1'b0, debug_halt = 1'b0, periph_powerdown = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, wdt_irq, wdt_reset_req, wdt_locked, er;
	int n_mismatch = 0, n_checks = 0, cyc = 0, n_rst, t0, t1, i;
	wdt_top wdt_top_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lp_osc(lp_osc), .debug_halt(debug_halt),
		.periph_powerdown(periph_powerdown), .wdt_irq(wdt_irq),
		.wdt_reset_req(wdt_reset_req), .wdt_locked(wdt_locked));
	wdt_core_model wdt_core_model_inst (.pclk(pclk), .wdt_reset_req(wdt_reset_req),
		.n_rst(n_rst));
	initial
		forever #25 pclk = ~pclk;
	// oscillator pin, eight clocks a period
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3)
			lp_osc <= ~lp_osc;
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, x);
		n_checks++;
		if (s !== x)
		begin
			n_mismatch++;
			$display("unexpected %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		if (n == 20)
		begin
			chk("ready", pready, 1'b1);
			conclude();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [31:0] a, d);
		apb(1'b1, a, d);
	endtask
	task automatic rf();
		apb(1'b1, WDT_ADDR_REFRESH, 32'h0);
	endtask
	// kind 0 waits for interrupt, 1 for a new reset request
	task automatic ev(input int lim, input logic kind, input logic exp);
		int n, b;
		n = 0;
		b = n_rst;
		while ((kind ? n_rst == b : wdt_irq !== 1'b1) && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
		t1 = cyc;
		chk(kind ? "reset request" : "interrupt", n < lim, exp);
		if (exp && n == lim)
			conclude();
	endtask
	initial
	begin
		#2ms;
		n_mismatch++;
		conclude();
	end
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		wr(WDT_ADDR_COUNT, 32'h1234);
		for (i = 0; i < 4; i++)
		begin
			apb(1'b0, WDT_ADDR_RELOAD + 4 * i, 32'h0);
			chk("reset value", rd, i < 2 ? 32'h40 : 32'h0);
		end
		apb(1'b0, 32'hFFFF0370, 32'h0);
		chk("slave error", er, 1'b1);
		$display("registers done");
		periph_powerdown <= 1'b1;
		wr(WDT_ADDR_RELOAD, 32'h0);
		for (i = 0; i < 3; i++)
		begin
			wr(WDT_ADDR_CTRL, 32'h00C0 | (i << 2));
			ev(3000, 1'b0, 1'b1);
			t0 = t1;
			rf();
			chk("irq cleared", wdt_irq, 1'b0);
			ev(3000, 1'b0, 1'b1);
			chk("tick period", t1 - t0, 8 << (4 * i));
			rf();
		end
		wr(WDT_ADDR_CTRL, 32'h00CC);
		rf();
		ev(600, 1'b0, 1'b0);
		wr(WDT_ADDR_CTRL, 32'h00C1);
		rf();
		ev(200, 1'b0, 1'b0);
		periph_powerdown <= 1'b0;
		ev(100, 1'b0, 1'b1);
		rf();
		$display("prescaler done");
		wr(WDT_ADDR_CTRL, 32'h0);
		rf();
		wr(WDT_ADDR_RELOAD, 32'hFFFD);
		wr(WDT_ADDR_CTRL, 32'h0180);
		ev(100, 1'b0, 1'b1);
		debug_halt <= 1'b1;
		repeat (40) @(posedge pclk);
		apb(1'b0, WDT_ADDR_COUNT, 32'h0);
		chk("wrapped count", rd, 32'h0);
		chk("irq held", wdt_irq, 1'b1);
		rf();
		chk("irq cleared", wdt_irq, 1'b0);
		debug_halt <= 1'b0;
		$display("normal mode done");
		wr(WDT_ADDR_CTRL, 32'h0);
		wr(WDT_ADDR_RELOAD, 32'h3);
		wr(WDT_ADDR_CTRL, 32'h0020);
		chk("locked", wdt_locked, 1'b1);
		wr(WDT_ADDR_RELOAD, 32'h100);
		wr(WDT_ADDR_CTRL, 32'h0);
		apb(1'b0, WDT_ADDR_RELOAD, 32'h0);
		chk("locked reload", rd, 32'h3);
		apb(1'b0, WDT_ADDR_CTRL, 32'h0);
		chk("locked control", rd, 32'h20);
		ev(100, 1'b1, 1'b1);
		ev(100, 1'b1, 1'b1);
		t0 = n_rst;
		for (i = 0; i < 30; i++)
			rf();
		chk("refresh holds off", n_rst - t0, 0);
		debug_halt <= 1'b1;
		ev(150, 1'b1, 1'b0);
		debug_halt <= 1'b0;
		ev(100, 1'b1, 1'b1);
		$display("watchdog done");
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("unlocked", wdt_locked, 1'b0);
		// four ticks at /256 keep the timeout above the software minimum
		wr(WDT_ADDR_RELOAD, 32'h4);
		wr(WDT_ADDR_CTRL, 32'h002A);
		t0 = n_rst;
		i = cyc;
		ev(9000, 1'b0, 1'b1);
		chk("timeout length", t1 - i > 8 * 256 * 3, 1'b1);
		chk("no reset request", n_rst - t0, 0);
		$display("irq watchdog done");
		conclude();
	end
endmodule
